// ===== hdl/rfid_irq_consts.svh
// Offsets, field positions, reset values and levels of the RFID
// interrupt and status register group and of its host bridge.
// Assumes inclusion by bare name from both ends.
`ifndef RFID_IRQ_CONSTS_SVH
`define RFID_IRQ_CONSTS_SVH

`define RFID_ADDR_MASK 6'h07
`define RFID_ADDR_FLAGS 6'h08
`define RFID_ADDR_FIFO 6'h09
`define RFID_ADDR_COLL 6'h0a
`define RFID_ADDR_TXLO 6'h0b
`define RFID_ADDR_TXHI 6'h0c

`define RFID_REG_RESET 8'h00
`define RFID_TXLO_WMASK 8'hfb
`define RFID_FLAG_OSC 7
`define RFID_FLAG_FIELD 6
`define RFID_FLAG_WL 5
`define RFID_FLAG_RXE 4
`define RFID_FLAG_TXE 3
`define RFID_FLAG_CODE 2
`define RFID_FLAG_CRC 1
`define RFID_FLAG_COL 0
`define RFID_TXLO_FOUR 1
`define RFID_TXLO_ANTCL 0

`define RFID_RX_LEVEL_0 6'd28
`define RFID_RX_LEVEL_1 6'd24
`define RFID_TX_LEVEL_0 6'd4
`define RFID_TX_LEVEL_1 6'd8

`define HOST_OFS_CMD 32'h0000_0000
`define HOST_OFS_STATUS 32'h0000_0004
`define HOST_CMD_ADDR_LSB 0
`define HOST_CMD_WE_BIT 8
`define HOST_CMD_DATA_LSB 16
`define HOST_ST_BUSY_BIT 0
`define HOST_ST_IRQ_BIT 1
`define HOST_ST_DATA_LSB 8
`define AXI_RESP_OKAY 2'b00
`define AXI_RESP_SLVERR 2'b10

`endif

// ===== hdl/rfid_irq_pkg.sv
// Types shared by the register group and its host bridge.
// Assumes nothing of its surroundings.
package rfid_irq_pkg;
    typedef enum logic [0:0] {
        HOST_IDLE = 1'b0,
        HOST_ACCESS = 1'b1
    } host_state_t;
endpackage

// ===== hdl/rfid_link_if.sv
// Register access link between the host bridge and the register group.
// Assumes both ends run on one common clock.
`timescale 1ns/1ns
interface rfid_link_if;
    logic req;
    logic we;
    logic [5:0] addr;
    logic [7:0] wdata;
    logic ack;
    logic [7:0] rdata;
    logic irq_out;

    modport dev (
        input req,
        input we,
        input addr,
        input wdata,
        output ack,
        output rdata,
        output irq_out
    );

    modport host (
        output req,
        output we,
        output addr,
        output wdata,
        input ack,
        input rdata,
        input irq_out
    );
endinterface

// ===== hdl/rfid_irq_device.sv
// Interrupt flags, mask, FIFO status, collision position and transmit
// length registers of the reader framing engine.
// Assumes event inputs are one-cycle pulses synchronous to clock.
`timescale 1ns/1ns
`include "rfid_irq_consts.svh"

module rfid_irq_device
    import rfid_irq_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    input wire logic ce,
    rfid_link_if.dev link,
    input wire logic set_default,
    input wire logic clear_cmd,
    input wire logic osc_enable,
    input wire logic osc_stable,
    input wire logic target_mode,
    input wire logic field_detect,
    input wire logic ca_field_abort,
    input wire logic iso_a_mode,
    input wire logic rx_start,
    input wire logic rx_end,
    input wire logic tx_busy,
    input wire logic tx_end,
    input wire logic parity_err,
    input wire logic framing_err,
    input wire logic crc_err,
    input wire logic collision,
    input wire logic [3:0] collision_byte_count,
    input wire logic [2:0] collision_bit_pos,
    input wire logic [5:0] fifo_count,
    input wire logic fifo_overflow,
    input wire logic rx_level_sel,
    input wire logic tx_level_sel,
    output logic [9:0] tx_byte_count,
    output logic [2:0] split_byte_bits,
    output logic four_bit_reply,
    output logic anticollision_frame
);
    logic [7:0] flags_reg;
    logic [7:0] mask_reg;
    logic [7:0] fifo_state_reg;
    logic [7:0] coll_reg;
    logic [7:0] txlo_reg;
    logic [7:0] txhi_reg;
    logic rx_act_reg;
    logic osc_prev_reg;
    logic field_prev_reg;
    logic rx_wl_prev_reg;
    logic tx_wl_prev_reg;
    logic ack_reg;
    logic [7:0] rdata_reg;

    // Register selects, shared by the write decode and the read mux
    wire sel_mask = (link.addr == `RFID_ADDR_MASK);
    wire sel_flags = (link.addr == `RFID_ADDR_FLAGS);
    wire sel_fifo = (link.addr == `RFID_ADDR_FIFO);
    wire sel_coll = (link.addr == `RFID_ADDR_COLL);
    wire sel_txlo = (link.addr == `RFID_ADDR_TXLO);
    wire sel_txhi = (link.addr == `RFID_ADDR_TXHI);

    // A held request is taken once; the ack cycle blocks a second take
    wire take = link.req && !ack_reg;
    wire wr_take = take && link.we;
    wire rd_take = take && !link.we;
    wire rd_flags = rd_take && sel_flags;
    wire wr_mask = wr_take && sel_mask;
    wire wr_txlo = wr_take && sel_txlo;
    wire wr_txhi = wr_take && sel_txhi;
    wire wipe = set_default || clear_cmd;

    wire osc_set = osc_enable && osc_stable && !osc_prev_reg;
    wire field_rise = field_detect && !field_prev_reg;
    wire field_set = (target_mode && !osc_enable && field_rise) ||
        ca_field_abort;

    wire [5:0] rx_level = rx_level_sel ? `RFID_RX_LEVEL_1 :
        `RFID_RX_LEVEL_0;
    wire [5:0] tx_level = tx_level_sel ? `RFID_TX_LEVEL_1 :
        `RFID_TX_LEVEL_0;
    wire rx_wl = rx_act_reg && (fifo_count >= rx_level);
    wire tx_wl = tx_busy && (fifo_count <= tx_level);
    // Edge of the level condition, so a slow drain raises one event only
    wire wl_set = (rx_wl && !rx_wl_prev_reg) ||
        (tx_wl && !tx_wl_prev_reg);
    wire code_set = parity_err || framing_err;
    wire col_set = collision && iso_a_mode;

    wire [7:0] flag_set = {osc_set, field_set, wl_set, rx_end, tx_end,
        code_set, crc_err, col_set};
    wire [7:0] read_clear = rd_flags ? 8'hff : 8'h00;
    // A new event in the read cycle survives the clear
    wire [7:0] flags_next = set_default ? `RFID_REG_RESET :
        ((flags_reg & ~read_clear) | flag_set);

    wire rx_act_next = clear_cmd || set_default ? 1'b0 :
        ((rx_act_reg || rx_start) && !rx_end);
    // Status is live and rebuilt every cycle; a wipe blanks one cycle
    wire [7:0] fifo_next = wipe ? `RFID_REG_RESET :
        {fifo_count, fifo_overflow, rx_act_next};

    // Position is kept until the next collision or a wipe
    wire [7:0] coll_next = wipe ? `RFID_REG_RESET :
        col_set ? {collision_byte_count, collision_bit_pos, 1'b0} :
        coll_reg;

    // Reply and frame controls drop once sent; a write that cycle wins
    wire [7:0] tx_done_clear = tx_end ?
        ((8'h01 << `RFID_TXLO_FOUR) | (8'h01 << `RFID_TXLO_ANTCL)) :
        8'h00;
    wire [7:0] txlo_next = set_default ? `RFID_REG_RESET :
        wr_txlo ? (link.wdata & `RFID_TXLO_WMASK) :
        (txlo_reg & ~tx_done_clear);
    wire [7:0] txhi_next = set_default ? `RFID_REG_RESET :
        wr_txhi ? link.wdata : txhi_reg;
    wire [7:0] mask_next = set_default ? `RFID_REG_RESET :
        wr_mask ? link.wdata : mask_reg;

    // Unmapped offsets read as zero
    wire [7:0] read_mux =
        sel_mask ? mask_reg :
        sel_flags ? flags_reg :
        sel_fifo ? fifo_state_reg :
        sel_coll ? coll_reg :
        sel_txlo ? txlo_reg :
        sel_txhi ? txhi_reg : 8'h00;

    always_ff @(posedge clock) begin
        if (reset) begin
            flags_reg <= `RFID_REG_RESET;
            mask_reg <= `RFID_REG_RESET;
            fifo_state_reg <= `RFID_REG_RESET;
            coll_reg <= `RFID_REG_RESET;
            txlo_reg <= `RFID_REG_RESET;
            txhi_reg <= `RFID_REG_RESET;
            rx_act_reg <= 1'b0;
        end else if (ce) begin
            flags_reg <= flags_next;
            mask_reg <= mask_next;
            fifo_state_reg <= fifo_next;
            coll_reg <= coll_next;
            txlo_reg <= txlo_next;
            txhi_reg <= txhi_next;
            rx_act_reg <= rx_act_next;
        end
    end

    // Idle levels are low, so no false edge follows reset
    always_ff @(posedge clock) begin
        if (reset) begin
            osc_prev_reg <= 1'b0;
            field_prev_reg <= 1'b0;
            rx_wl_prev_reg <= 1'b0;
            tx_wl_prev_reg <= 1'b0;
        end else if (ce) begin
            osc_prev_reg <= osc_stable;
            field_prev_reg <= field_detect;
            rx_wl_prev_reg <= rx_wl;
            tx_wl_prev_reg <= tx_wl;
        end
    end

    // One-cycle ack; read data holds until the next read
    always_ff @(posedge clock) begin
        if (reset) begin
            ack_reg <= 1'b0;
            rdata_reg <= 8'h00;
        end else if (ce) begin
            ack_reg <= take;
            if (rd_take) begin
                rdata_reg <= read_mux;
            end
        end
    end

    assign link.ack = ack_reg;
    assign link.rdata = rdata_reg;
    // Level output: stays high until the host reads or masks the flags, or set_default clears them
    assign link.irq_out = |(flags_reg & ~mask_reg);
    assign tx_byte_count = {txhi_reg, txlo_reg[7:6]};
    assign split_byte_bits = txlo_reg[5:3];
    assign four_bit_reply = txlo_reg[`RFID_TXLO_FOUR];
    assign anticollision_frame = txlo_reg[`RFID_TXLO_ANTCL];
endmodule

// ===== hdl/rfid_irq_host.sv
// Host bridge: AXI4-Lite slave with a command and a status word that
// runs single register accesses on the link to the register group.
// Assumes AXI4-Lite masters and the link share clock.
`timescale 1ns/1ns
`include "rfid_irq_consts.svh"

module rfid_irq_host
    import rfid_irq_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    input wire logic ce,
    rfid_link_if.host link,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic irq
);
    host_state_t state_reg;
    logic aw_held_reg;
    logic w_held_reg;
    logic [31:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic rvalid_reg;
    logic [1:0] rresp_reg;
    logic [31:0] rdata_reg;
    logic we_reg;
    logic [5:0] addr_reg;
    logic [7:0] wbyte_reg;
    logic [7:0] last_rd_reg;

    wire busy = (state_reg == HOST_ACCESS);
    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire ar_take = s_axi_arvalid && s_axi_arready;
    wire do_write = aw_held_reg && w_held_reg && !bvalid_reg;
    wire cmd_hit = (awaddr_reg[31:2] == 30'(`HOST_OFS_CMD >> 2));
    // Byte strobes are ignored: every command is one whole word
    wire wstrb_full = 1'b1;
    // A command while busy is refused rather than queued
    wire start = do_write && cmd_hit && !busy && wstrb_full;
    wire st_hit = (s_axi_araddr[31:2] == 30'(`HOST_OFS_STATUS >> 2));
    wire [31:0] status_word = {16'h0000, last_rd_reg, 6'b00_0000,
        link.irq_out, busy};

    always_ff @(posedge clock) begin
        if (reset) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            awaddr_reg <= 32'h0000_0000;
            wdata_reg <= 32'h0000_0000;
            bvalid_reg <= 1'b0;
            bresp_reg <= `AXI_RESP_OKAY;
        end else if (ce) begin
            if (aw_take) begin
                aw_held_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
            end
            if (w_take) begin
                w_held_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
            end
            if (do_write) begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                bvalid_reg <= 1'b1;
                bresp_reg <= start ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            rvalid_reg <= 1'b0;
            rresp_reg <= `AXI_RESP_OKAY;
            rdata_reg <= 32'h0000_0000;
        end else if (ce) begin
            if (ar_take) begin
                rvalid_reg <= 1'b1;
                rresp_reg <= st_hit ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
                rdata_reg <= st_hit ? status_word : 32'h0000_0000;
            end else if (s_axi_rready) begin
                rvalid_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            state_reg <= HOST_IDLE;
            we_reg <= 1'b0;
            addr_reg <= 6'h00;
            wbyte_reg <= 8'h00;
            last_rd_reg <= 8'h00;
        end else if (ce) begin
            case (state_reg)
                HOST_IDLE: begin
                    if (start) begin
                        state_reg <= HOST_ACCESS;
                        we_reg <= wdata_reg[`HOST_CMD_WE_BIT];
                        addr_reg <= wdata_reg[5:0];
                        wbyte_reg <= wdata_reg[23:16];
                    end
                end
                HOST_ACCESS: begin
                    if (link.ack) begin
                        state_reg <= HOST_IDLE;
                        if (!we_reg) begin
                            last_rd_reg <= link.rdata;
                        end
                    end
                end
                default: begin
                    state_reg <= HOST_IDLE;
                end
            endcase
        end
    end

    assign s_axi_awready = !aw_held_reg && !bvalid_reg;
    assign s_axi_wready = !w_held_reg && !bvalid_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rresp = rresp_reg;
    assign s_axi_rdata = rdata_reg;
    // Request held until the ack; the device takes it exactly once
    assign link.req = busy && !link.ack;
    assign link.we = we_reg;
    assign link.addr = addr_reg;
    assign link.wdata = wbyte_reg;
    assign irq = link.irq_out;
endmodule

// ===== dv/rfid_irq_asserts.sv
// Checker on the link between the host bridge and the register group.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ns
module rfid_irq_asserts (
    input wire logic clock,
    input wire logic reset,
    input wire logic set_default,
    input wire logic req,
    input wire logic we,
    input wire logic [5:0] addr,
    input wire logic [7:0] wdata,
    input wire logic ack,
    input wire logic [7:0] rdata,
    input wire logic irq_out
);
    logic [7:0] mask_reg;
    logic [7:0] txhi_reg;
    wire take = req && !ack;
    wire rd = ack && !we;

    // Shadows follow only link writes; set_default clears both
    always_ff @(posedge clock) begin
        if (reset || set_default) begin
            mask_reg <= 8'h00;
            txhi_reg <= 8'h00;
        end else if (take && we && addr == 6'h07) begin
            mask_reg <= wdata;
        end else if (take && we && addr == 6'h0c) begin
            txhi_reg <= wdata;
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);

    property p_ack_pulse;
        ack |=> !ack;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("ack longer than one cycle");
    property p_take_ack;
        take |=> ack;
    endproperty
    a_take_ack: assert property (p_take_ack)
        else $error("request not answered next cycle");
    property p_mask_rd;
        rd && addr == 6'h07 |-> rdata == mask_reg;
    endproperty
    a_mask_rd: assert property (p_mask_rd)
        else $error("mask read differs from written value");
    property p_txhi_rd;
        rd && addr == 6'h0c |-> rdata == txhi_reg;
    endproperty
    a_txhi_rd: assert property (p_txhi_rd)
        else $error("length high read differs");
    property p_txlo_rsv;
        rd && addr == 6'h0b |-> !rdata[2];
    endproperty
    a_txlo_rsv: assert property (p_txlo_rsv)
        else $error("unused length bit reads one");
    property p_coll_b0;
        rd && addr == 6'h0a |-> !rdata[0];
    endproperty
    a_coll_b0: assert property (p_coll_b0)
        else $error("collision bit 0 reads one");
    property p_fifo_range;
        rd && addr == 6'h09 |-> rdata[7:2] <= 6'd32;
    endproperty
    a_fifo_range: assert property (p_fifo_range)
        else $error("unread count out of range");
    property p_unmapped;
        rd && (addr < 6'h07 || addr > 6'h0c) |-> rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    property p_irq_flags;
        rd && addr == 6'h08 |-> $past(irq_out) == |(rdata & ~mask_reg);
    endproperty
    a_irq_flags: assert property (p_irq_flags)
        else $error("irq disagrees with unmasked flags");
endmodule

// ===== dv/tb_top.sv
// Bench driving the register group through the AXI4-Lite bridge.
// Assumes both ends and the bench share one 100 MHz clock.
`timescale 1ns/1ns
module tb_top;
    logic clock = 0;
    logic reset = 1;
    logic ce = 1;
    logic target_mode = 1;
    logic iso_a_mode = 0, fifo_overflow = 0, rx_level_sel = 0;
    logic tx_level_sel = 0;
    logic [3:0] collision_byte_count = 0;
    logic [2:0] collision_bit_pos = 0;
    logic [5:0] fifo_count = 0;
    logic [12:0] ev = 0;
    wire collision = ev[0], crc_err = ev[1], parity_err = ev[2];
    wire tx_end = ev[3], rx_end = ev[4], tx_busy = ev[5];
    wire ca_field_abort = ev[6], osc_stable = ev[7], osc_enable = ev[7];
    wire field_detect = ev[8], framing_err = ev[9], rx_start = ev[10];
    wire clear_cmd = ev[11], set_default = ev[12];
    logic [9:0] tx_byte_count;
    logic [2:0] split_byte_bits;
    logic four_bit_reply, anticollision_frame;
    logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    int n_mismatch = 0;
    int samples_checked = 0;
    integer seed = 32'h89e9;
    logic [7:0] expq[$];

    rfid_link_if link ();
    rfid_irq_device i_rfid_irq_device (.*);
    rfid_irq_host i_rfid_irq_host (.*);
    rfid_irq_asserts i_rfid_irq_asserts (.clock, .reset, .set_default,
        .req(link.req), .we(link.we), .addr(link.addr),
        .wdata(link.wdata), .ack(link.ack), .rdata(link.rdata),
        .irq_out(link.irq_out));

    initial begin
        forever #5 clock = ~clock;
    end

    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tally_and_finish;
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic timed_out;
        n_mismatch++;
        tally_and_finish;
    endtask

    task automatic axi_wr(input logic [31:0] a, d, input logic [1:0] er);
        bit done;
        done = 0;
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        for (int n = 0; n < 50 && !done; n++) begin
            @(posedge clock);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
            if (s_axi_bvalid) begin
                check("bresp", s_axi_bresp, er);
                s_axi_bready <= 0;
                done = 1;
            end
        end
        if (!done) timed_out;
    endtask

    task automatic axi_rd(input logic [31:0] a, input logic [1:0] er,
        output logic [31:0] d);
        bit done;
        done = 0;
        @(posedge clock);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        for (int n = 0; n < 50 && !done; n++) begin
            @(posedge clock);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
            if (s_axi_rvalid) begin
                d = s_axi_rdata;
                check("rresp", s_axi_rresp, er);
                s_axi_rready <= 0;
                done = 1;
            end
        end
        if (!done) timed_out;
    endtask

    // Command word, then poll status until the link access is over
    task automatic link_op(input logic w, input logic [5:0] a,
        input logic [7:0] wd, output logic [31:0] st);
        axi_wr(32'h0000_0000, {8'h00, wd, 7'h00, w, 2'b00, a}, 2'b00);
        st = 32'h0000_0001;
        for (int n = 0; n < 20 && st[0]; n++) axi_rd(32'h0000_0004, 2'b00, st);
        if (st[0]) timed_out;
    endtask

    task automatic link_rd(input logic [5:0] a, input logic [7:0] e);
        logic [31:0] st;
        expq.push_back(e);
        link_op(1'b0, a, 8'h00, st);
        check("status byte", st[15:8], e);
    endtask

    task automatic link_wr(input logic [5:0] a, input logic [7:0] d);
        logic [31:0] st;
        link_op(1'b1, a, d, st);
    endtask

    task automatic fire(input int i);
        @(posedge clock);
        ev <= 13'h0001 << i;
        @(posedge clock);
        ev <= 13'h0000;
    endtask

    always @(posedge clock) begin
        if (!reset && link.ack && !link.we) begin
            if (expq.size() == 0) check("unexpected read", 32'h1, 32'h0);
            else check("link rdata", link.rdata, expq.pop_front());
        end
    end

    initial begin
        repeat (100000) @(posedge clock);
        timed_out;
    end

    initial begin
        logic [7:0] m, hi;
        logic [31:0] st;
        int b;
        repeat (5) @(posedge clock);
        reset <= 0;
        for (int a = 6; a <= 13; a++) link_rd(6'(a), 8'h00);
        link_rd(6'h3f, 8'h00);
        m = 8'($random(seed));
        hi = 8'($random(seed));
        link_wr(6'h07, m);
        link_wr(6'h0b, 8'hff);
        link_wr(6'h0c, hi);
        link_rd(6'h07, m);
        link_rd(6'h0b, 8'hfb);
        check("tx fields", {tx_byte_count, split_byte_bits, four_bit_reply,
            anticollision_frame}, {hi, 2'b11, 3'h7, 2'b11});
        iso_a_mode <= 1;
        collision_byte_count <= 4'($random(seed));
        collision_bit_pos <= 3'($random(seed));
        for (int i = 0; i < 10; i++) begin
            b = i < 8 ? i : (i == 8 ? 6 : 2);
            fire(i);
            repeat (2) @(posedge clock);
            check("irq", irq, !m[b]);
            link_rd(6'h08, 8'h01 << b);
            link_rd(6'h08, 8'h00);
        end
        link_rd(6'h0a, {collision_byte_count, collision_bit_pos, 1'b0});
        link_rd(6'h0b, 8'hf8);
        check("tx fields", {tx_byte_count, split_byte_bits, four_bit_reply,
            anticollision_frame}, {hi, 2'b11, 3'h7, 2'b00});
        iso_a_mode <= 0;
        fire(0);
        link_rd(6'h08, 8'h00);
        rx_level_sel <= 1;
        fifo_count <= 6'd26;
        fifo_overflow <= 1;
        fire(10);
        link_rd(6'h09, {6'd26, 2'b11});
        fire(4);
        link_rd(6'h09, {6'd26, 2'b10});
        link_rd(6'h08, 8'h30);
        tx_level_sel <= 1;
        fifo_count <= 6'd8;
        fire(5);
        link_rd(6'h08, 8'h20);
        tx_level_sel <= 0;
        fire(5);
        link_rd(6'h08, 8'h00);
        rx_level_sel <= 0;
        fifo_count <= 6'd26;
        fire(10);
        link_rd(6'h08, 8'h00);
        fire(4);
        link_rd(6'h08, 8'h10);
        fire(11);
        link_rd(6'h0a, 8'h00);
        fire(1);
        fire(12);
        repeat (2) @(posedge clock);
        check("irq", irq, 1'b0);
        for (int a = 7; a <= 12; a++) if (a != 9) link_rd(6'(a), 8'h00);
        ce <= 0;
        fire(7);
        @(posedge clock);
        ce <= 1;
        link_rd(6'h08, 8'h00);
        check("irq", irq, 1'b0);
        axi_wr(32'h0000_0008, 32'h0000_0000, 2'b10);
        axi_rd(32'h0000_0000, 2'b10, st);
        check("bad read data", st, 32'h0000_0000);
        tally_and_finish;
    end
endmodule
